/* File: include/tmac_pkg.sv */
// Constants and types shared by the table multiply-accumulate unit
package tmac_pkg;

    // APB register byte offsets
    localparam logic [7:0] TMAC_OFF_CTRL = 8'h00;
    localparam logic [7:0] TMAC_OFF_TADDR = 8'h04;
    localparam logic [7:0] TMAC_OFF_DADDR = 8'h08;
    localparam logic [7:0] TMAC_OFF_PREF = 8'h0c;
    localparam logic [7:0] TMAC_OFF_STAT = 8'h10;
    localparam logic [7:0] TMAC_OFF_ACC = 8'h14;
    localparam logic [7:0] TMAC_OFF_PROD = 8'h18;
    localparam logic [7:0] TMAC_OFF_TREG = 8'h1c;
    localparam logic [7:0] TMAC_OFF_CSTK = 8'h20;

    // Control register field positions
    localparam int TMAC_CTRL_GO = 0;
    localparam int TMAC_CTRL_MOVE = 1;
    localparam int TMAC_CTRL_DIRECT = 2;
    localparam int TMAC_CTRL_STEP_LSB = 3;
    localparam int TMAC_CTRL_SHIFT_LSB = 5;
    localparam int TMAC_CTRL_SAT = 7;
    localparam int TMAC_CTRL_PCFG = 8;
    localparam int TMAC_CTRL_REP_LSB = 16;

    // Status register field positions
    localparam int TMAC_STAT_BUSY = 0;
    localparam int TMAC_STAT_CARRY = 1;
    localparam int TMAC_STAT_OV = 2;

    // Cycles spent before the first iteration
    localparam logic [1:0] TMAC_SETUP_RAM = 2'd2;
    localparam logic [1:0] TMAC_SETUP_OTHER = 2'd3;

    // Memory regions
    localparam logic [7:0] TMAC_BLK0_PAGE = 8'hff;
    localparam logic [15:0] TMAC_ROM_TOP = 16'h1000;
    localparam logic [15:0] TMAC_B2_LO = 16'h0060;
    localparam logic [15:0] TMAC_B2_HI = 16'h007f;
    localparam logic [15:0] TMAC_BLK0_LO = 16'h0200;
    localparam logic [15:0] TMAC_B1_HI = 16'h03ff;
    localparam logic [15:0] TMAC_B1_LO = 16'h0300;

    // Reset values and saturation limits
    localparam logic [15:0] TMAC_ADDR_RST = 16'h0000;
    localparam logic [31:0] TMAC_WORD_RST = 32'h00000000;
    localparam logic [31:0] TMAC_SAT_POS = 32'h7fffffff;
    localparam logic [31:0] TMAC_SAT_NEG = 32'h80000000;

    typedef enum logic [1:0] {
        TMAC_SHIFT_NONE, TMAC_SHIFT_L1, TMAC_SHIFT_L4, TMAC_SHIFT_R6
    } tmac_shift_t;

    typedef enum logic [1:0] {
        TMAC_STEP_NONE, TMAC_STEP_INC, TMAC_STEP_DEC, TMAC_STEP_RSV
    } tmac_step_t;

    typedef struct packed {
        logic [7:0] repCount;
        tmac_shift_t shiftMode;
        tmac_step_t step;
        logic progCfg;
        logic satMode;
        logic direct;
        logic move;
    } tmac_ctrl_t;

    localparam tmac_ctrl_t TMAC_CTRL_RST = '0;

    typedef enum logic [1:0] {TMAC_IDLE, TMAC_SETUP, TMAC_RUN} tmac_state_t;

endpackage

/* File: core/tmac_accum.sv */
// Product shifter and saturating accumulator adder
`timescale 1ns/1ps
module tmac_accum import tmac_pkg::*; (
    input wire logic [31:0] acc,
    input wire logic [31:0] prod,
    input wire tmac_shift_t shiftMode,
    input wire logic satMode,
    output logic [31:0] sum,
    output logic carry,
    output logic ovf
);
    logic [31:0] shifted;
    logic [32:0] raw;

    always_comb begin
        case (shiftMode)
            TMAC_SHIFT_L1: shifted = {prod[30:0], 1'b0};
            TMAC_SHIFT_L4: shifted = {prod[27:0], 4'h0};
            TMAC_SHIFT_R6: shifted = {{6{prod[31]}}, prod[31:6]};
            default: shifted = prod;
        endcase
    end

    assign raw = {1'b0, acc} + {1'b0, shifted};
    assign carry = raw[32];
    assign ovf = (acc[31] == shifted[31]) && (raw[31] != acc[31]);

    always_comb begin
        if (ovf && satMode) begin
            sum = acc[31] ? TMAC_SAT_NEG : TMAC_SAT_POS;
        end else begin
            sum = raw[31:0];
        end
    end
endmodule

/* File: core/tmac_unit.sv */
// Table multiply-accumulate unit with APB register access
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps

// Operation
// - Multiply data by table, accumulate shifted product
// - Move variant also shifts data word upward
// - Operands may come from any memory
// - Direct mode keeps data address fixed
// - Table address steps by one per repetition
// - Repeated iterations take one cycle each, 1+p each with an external table
// - No move for registers or external data
// - Move confined to on-chip blocks zero-two
// - RAM table: 3 single, 2+n repeated
// - ROM table: 4 single, 3+n repeated
// - External table: 4+p single, 3+n+np repeated
// - Move copies word to next higher address
// - Move runs across block zero-one boundary
module tmac_unit import tmac_pkg::*; (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [15:0] pmAddr,
    output logic pmRd,
    input wire logic [15:0] pmData,
    input wire logic pmReady,
    output logic [15:0] dmAddr,
    output logic dmRd,
    input wire logic [15:0] dmData,
    output logic dmWr,
    output logic [15:0] dmWrAddr,
    output logic [15:0] dmWrData,
    output logic busy
);
    tmac_state_t state_ff;
    tmac_ctrl_t ctrl_ff;
    tmac_ctrl_t nxt_ctrl;
    logic [15:0] taddr_ff;
    logic [15:0] daddr_ff;
    logic [15:0] prefetch_ff;
    logic [15:0] callStack_ff;
    logic [31:0] acc_ff;
    logic [31:0] prod_ff;
    logic [15:0] treg_ff;
    logic carry_ff;
    logic ov_ff;
    logic busy_ff;
    logic fetch_ff;
    logic tableExt_ff;
    logic [1:0] setupCnt_ff;
    logic [7:0] remain_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic dmWr_ff;
    logic [15:0] dmWrAddr_ff;
    logic [15:0] dmWrData_ff;

    logic wrEn;
    logic rdPhase;
    logic go;
    logic tableRam;
    logic tableRom;
    logic iterate;
    logic lastIter;
    logic moveOk;
    logic inLowBlocks;
    logic inBlockTwo;
    logic [31:0] rdMux;
    logic mapped;
    logic [31:0] sum;
    logic addCarry;
    logic addOvf;
    logic [31:0] newProd;

    // A write lands on the completing access edge only
    assign wrEn = psel && penable && pready_ff && pwrite;
    assign rdPhase = psel && penable && !pready_ff;

    always_comb begin
        nxt_ctrl.move = pwdata[TMAC_CTRL_MOVE];
        nxt_ctrl.direct = pwdata[TMAC_CTRL_DIRECT];
        nxt_ctrl.step = tmac_step_t'(pwdata[TMAC_CTRL_STEP_LSB +: 2]);
        nxt_ctrl.shiftMode = tmac_shift_t'(pwdata[TMAC_CTRL_SHIFT_LSB +: 2]);
        nxt_ctrl.satMode = pwdata[TMAC_CTRL_SAT];
        nxt_ctrl.progCfg = pwdata[TMAC_CTRL_PCFG];
        nxt_ctrl.repCount = pwdata[TMAC_CTRL_REP_LSB +: 8];
    end

    // Start is taken only when idle; a second start is dropped
    assign go = wrEn && (paddr == TMAC_OFF_CTRL) && pwdata[TMAC_CTRL_GO]
        && (state_ff == TMAC_IDLE);

    // Table location picks the setup length
    assign tableRam = (taddr_ff[15:8] == TMAC_BLK0_PAGE) && nxt_ctrl.progCfg;
    assign tableRom = !tableRam && (taddr_ff < TMAC_ROM_TOP);

    // External table fetch stalls on wait states
    assign iterate = (state_ff == TMAC_RUN) && (!tableExt_ff || pmReady);
    assign lastIter = iterate && (remain_ff == 8'h00);

    // Blocks zero and one form one run; block zero only as data
    assign inLowBlocks = (daddr_ff >= TMAC_BLK0_LO)
        && (daddr_ff <= TMAC_B1_HI)
        && (!ctrl_ff.progCfg || (daddr_ff >= TMAC_B1_LO));
    assign inBlockTwo = (daddr_ff >= TMAC_B2_LO)
        && (daddr_ff <= TMAC_B2_HI);

    // Registers and external data: plain accumulate, no move
    assign moveOk = ctrl_ff.move && (inLowBlocks || inBlockTwo);

    // Product of the fresh multiplicand and the table word
    assign newProd = $signed(dmData) * $signed(pmData);

    tmac_accum u_accum (
        .acc(acc_ff),
        .prod(prod_ff),
        .shiftMode(ctrl_ff.shiftMode),
        .satMode(ctrl_ff.satMode),
        .sum(sum),
        .carry(addCarry),
        .ovf(addOvf)
    );

    always_comb begin
        mapped = 1'b1;
        rdMux = TMAC_WORD_RST;
        case (paddr)
            TMAC_OFF_CTRL: begin
                rdMux[TMAC_CTRL_MOVE] = ctrl_ff.move;
                rdMux[TMAC_CTRL_DIRECT] = ctrl_ff.direct;
                rdMux[TMAC_CTRL_STEP_LSB +: 2] = ctrl_ff.step;
                rdMux[TMAC_CTRL_SHIFT_LSB +: 2] = ctrl_ff.shiftMode;
                rdMux[TMAC_CTRL_SAT] = ctrl_ff.satMode;
                rdMux[TMAC_CTRL_PCFG] = ctrl_ff.progCfg;
                rdMux[TMAC_CTRL_REP_LSB +: 8] = ctrl_ff.repCount;
            end
            TMAC_OFF_TADDR: rdMux[15:0] = taddr_ff;
            TMAC_OFF_DADDR: rdMux[15:0] = daddr_ff;
            TMAC_OFF_PREF: rdMux[15:0] = prefetch_ff;
            TMAC_OFF_STAT: begin
                rdMux[TMAC_STAT_BUSY] = busy_ff;
                rdMux[TMAC_STAT_CARRY] = carry_ff;
                rdMux[TMAC_STAT_OV] = ov_ff;
            end
            TMAC_OFF_ACC: rdMux = acc_ff;
            TMAC_OFF_PROD: rdMux = prod_ff;
            TMAC_OFF_TREG: rdMux[15:0] = treg_ff;
            TMAC_OFF_CSTK: rdMux[15:0] = callStack_ff;
            default: mapped = 1'b0;
        endcase
    end

    // APB answer: one extra access cycle, then pready for one cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pready_ff <= 1'b0;
            prdata_ff <= TMAC_WORD_RST;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= rdPhase;
            if (rdPhase) begin
                prdata_ff <= pwrite ? TMAC_WORD_RST : rdMux;
                pslverr_ff <= !mapped;
            end else begin
                prdata_ff <= TMAC_WORD_RST;
                pslverr_ff <= 1'b0;
            end
        end
    end

    // Configuration and table address, frozen while busy
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff <= TMAC_CTRL_RST;
            taddr_ff <= TMAC_ADDR_RST;
        end else if (wrEn && (state_ff == TMAC_IDLE)) begin
            if (paddr == TMAC_OFF_CTRL) begin
                ctrl_ff <= nxt_ctrl;
            end
            if (paddr == TMAC_OFF_TADDR) begin
                taddr_ff <= pwdata[15:0];
            end
        end
    end

    // Sequencer
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= TMAC_IDLE;
            setupCnt_ff <= 2'd0;
            remain_ff <= 8'h00;
            tableExt_ff <= 1'b0;
            busy_ff <= 1'b0;
            fetch_ff <= 1'b0;
        end else begin
            case (state_ff)
                TMAC_IDLE: begin
                    if (go) begin
                        state_ff <= TMAC_SETUP;
                        busy_ff <= 1'b1;
                        remain_ff <= nxt_ctrl.repCount;
                        // Table class is fixed at the start edge
                        tableExt_ff <= !tableRam && !tableRom;
                        if (tableRam) begin
                            setupCnt_ff <= TMAC_SETUP_RAM - 2'd1;
                        end else begin
                            setupCnt_ff <= TMAC_SETUP_OTHER
                                - 2'd1;
                        end
                    end
                end
                TMAC_SETUP: begin
                    if (setupCnt_ff == 2'd0) begin
                        state_ff <= TMAC_RUN;
                        fetch_ff <= 1'b1;
                    end else begin
                        setupCnt_ff <= setupCnt_ff - 2'd1;
                    end
                end
                TMAC_RUN: begin
                    // One cycle per iteration once running; an external table adds its wait states
                    if (lastIter) begin
                        state_ff <= TMAC_IDLE;
                        busy_ff <= 1'b0;
                        fetch_ff <= 1'b0;
                    end else if (iterate) begin
                        remain_ff <= remain_ff - 8'h01;
                    end
                end
                default: begin
                    state_ff <= TMAC_IDLE;
                    busy_ff <= 1'b0;
                    fetch_ff <= 1'b0;
                end
            endcase
        end
    end

    // Prefetch counter and microcall stack
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prefetch_ff <= TMAC_ADDR_RST;
            callStack_ff <= TMAC_ADDR_RST;
        end else if (go) begin
            callStack_ff <= prefetch_ff;
            prefetch_ff <= taddr_ff;
        end else if (lastIter) begin
            prefetch_ff <= callStack_ff;
        end else if (iterate) begin
            prefetch_ff <= prefetch_ff + 16'h0001;
        end else if (wrEn && (paddr == TMAC_OFF_PREF)
            && (state_ff == TMAC_IDLE)) begin
            prefetch_ff <= pwdata[15:0];
        end
    end

    // Data address: fixed in direct mode, stepped per the step field when indirect
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            daddr_ff <= TMAC_ADDR_RST;
        end else if (iterate && !lastIter && !ctrl_ff.direct) begin
            case (ctrl_ff.step)
                TMAC_STEP_INC: daddr_ff <= daddr_ff + 16'h0001;
                TMAC_STEP_DEC: daddr_ff <= daddr_ff - 16'h0001;
                default: daddr_ff <= daddr_ff;
            endcase
        end else if (wrEn && (paddr == TMAC_OFF_DADDR)
            && (state_ff == TMAC_IDLE)) begin
            daddr_ff <= pwdata[15:0];
        end
    end

    // Accumulator, product and multiplicand
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            acc_ff <= TMAC_WORD_RST;
            prod_ff <= TMAC_WORD_RST;
            treg_ff <= TMAC_ADDR_RST;
            carry_ff <= 1'b0;
        end else if (iterate) begin
            acc_ff <= sum;
            carry_ff <= addCarry;
            treg_ff <= dmData;
            prod_ff <= newProd;
        end else if (wrEn && (paddr == TMAC_OFF_ACC)
            && (state_ff == TMAC_IDLE)) begin
            acc_ff <= pwdata;
        end
    end

    // Sticky overflow; a new overflow beats a clear
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ov_ff <= 1'b0;
        end else if (iterate && addOvf) begin
            ov_ff <= 1'b1;
        end else if (wrEn && (paddr == TMAC_OFF_STAT)
            && pwdata[TMAC_STAT_OV]) begin
            ov_ff <= 1'b0;
        end
    end

    // Data move writes the read word one address higher
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dmWr_ff <= 1'b0;
            dmWrAddr_ff <= TMAC_ADDR_RST;
            dmWrData_ff <= TMAC_ADDR_RST;
        end else begin
            dmWr_ff <= iterate && moveOk;
            if (iterate && moveOk) begin
                dmWrAddr_ff <= daddr_ff + 16'h0001;
                dmWrData_ff <= dmData;
            end
        end
    end

    // Every output comes straight from its flop
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign pmAddr = prefetch_ff;
    assign pmRd = fetch_ff;
    assign dmAddr = daddr_ff;
    assign dmRd = fetch_ff;
    assign dmWr = dmWr_ff;
    assign dmWrAddr = dmWrAddr_ff;
    assign dmWrData = dmWrData_ff;
    assign busy = busy_ff;
endmodule

/* File: verification/tmac_mem_model.sv */
// Table and data memory model facing the multiply-accumulate unit
`timescale 1ns/1ps
module tmac_mem_model (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [1:0] waitN,
    input wire logic [15:0] pmAddr,
    input wire logic pmRd,
    output logic [15:0] pmData,
    output logic pmReady,
    input wire logic [15:0] dmAddr,
    input wire logic dmRd,
    output logic [15:0] dmData
);
    logic [1:0] waitCnt_ff;
    logic [15:0] pmHold_ff;
    logic [15:0] dmHold_ff;
    // Same wait count on every table access
    assign pmReady = waitCnt_ff == waitN;
    // Any address answers; idle lines toggle each cycle
    assign pmData = pmRd && pmReady ? pmAddr + 16'h0011 : ~pmHold_ff;
    assign dmData = dmRd ? dmAddr ^ 16'h0005 : ~dmHold_ff;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            waitCnt_ff <= 2'h0;
        end else if (pmRd && !pmReady) begin
            waitCnt_ff <= waitCnt_ff + 2'h1;
        end else begin
            waitCnt_ff <= 2'h0;
        end
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pmHold_ff <= 16'h0000;
            dmHold_ff <= 16'h0000;
        end else begin
            pmHold_ff <= pmData;
            dmHold_ff <= dmData;
        end
    end
endmodule

/* File: verification/tmac_unit_checker.sv */
// Port-level assertions for the table multiply-accumulate unit
`timescale 1ns/1ps
module tmac_unit_checker import tmac_pkg::*; (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [15:0] pmAddr,
    input wire logic pmRd,
    input wire logic [15:0] pmData,
    input wire logic pmReady,
    input wire logic [15:0] dmAddr,
    input wire logic dmRd,
    input wire logic [15:0] dmData,
    input wire logic dmWr,
    input wire logic [15:0] dmWrAddr,
    input wire logic [15:0] dmWrData,
    input wire logic busy
);
    logic directFf;
    wire ctrlWr = psel && penable && pready && pwrite
        && paddr == TMAC_OFF_CTRL;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Direct mode as last accepted while idle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            directFf <= 1'b0;
        end else if (ctrlWr && !busy) begin
            directFf <= pwdata[TMAC_CTRL_DIRECT];
        end
    end
    sequence iterDone;
        pmRd && pmReady;
    endsequence
    sequence iterThenNext;
        iterDone ##1 pmRd;
    endsequence
    table_step_a: assert property (iterThenNext |->
        pmAddr == $past(pmAddr) + 16'h0001) else $error("table step");
    direct_hold_a: assert property (iterDone ##1 (pmRd && directFf)
        |-> dmAddr == $past(dmAddr)) else $error("data address moved");
    run_end_a: assert property ($fell(pmRd) |-> $fell(busy))
        else $error("busy outlasts run");
    setup_min_a: assert property ($rose(pmRd) |-> $past(busy, 2))
        else $error("setup too short");
    move_copy_a: assert property (dmWr |-> $past(dmRd) &&
        dmWrAddr == $past(dmAddr) + 16'h0001 && dmWrData == $past(dmData))
        else $error("move copy wrong");
    move_range_a: assert property (dmWr |->
        ($past(dmAddr) >= TMAC_B2_LO && $past(dmAddr) <= TMAC_B2_HI) ||
        ($past(dmAddr) >= TMAC_BLK0_LO && $past(dmAddr) <= TMAC_B1_HI))
        else $error("move outside blocks");
    go_start_a: assert property (ctrlWr && pwdata[TMAC_CTRL_GO]
        && !busy |=> busy) else $error("start missed");
    apb_answer_a: assert property (psel && penable && !$past(penable)
        |-> !pready ##1 pready) else $error("access length");
    apb_err_a: assert property (pready && paddr > TMAC_OFF_CSTK |-> pslverr)
        else $error("unmapped accepted");
endmodule
bind tmac_unit tmac_unit_checker chk (.*);

/* File: verification/tb.sv */
// Self-checking testbench for the table multiply-accumulate unit
`timescale 1ns/1ps
module tb import tmac_pkg::*; ;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [1:0] waitN = 2'h0;
    logic [31:0] prdata, expP = 32'h0;
    logic pready, pslverr, pmRd, pmReady, dmRd, dmWr, busy;
    logic [15:0] pmAddr, pmData, dmAddr, dmData, dmWrAddr, dmWrData;
    int n_fail = 0;
    int comparisons = 0;
    tmac_unit dut (.*);
    tmac_mem_model mem (.*);
    always #2 mclk = ~mclk;
    task complete_run;
        $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task check(input string what, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task apb(input logic [7:0] a, input logic w, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        int k;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (k >= 16) begin
            n_fail++;
            complete_run();
        end else begin
            r = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(a, 1'b1, d, r, e);
    endtask
    task rdChk(input string what, input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(a, 1'b0, 32'h0, r, e);
        check(what, r, x);
    endtask
    // Memory contents, as the model serves them
    function automatic logic [15:0] pmv(input logic [15:0] a);
        return a + 16'h0011;
    endfunction
    function automatic logic [15:0] dmv(input logic [15:0] a);
        return a ^ 16'h0005;
    endfunction
    function automatic logic [31:0] shp(input logic [31:0] p,
                                        input logic [1:0] m);
        case (m)
            2'd1: return p << 1;
            2'd2: return p << 4;
            2'd3: return $signed(p) >>> 6;
            default: return p;
        endcase
    endfunction
    function automatic logic inMove(input logic [15:0] a, input logic pcfg);
        return (a >= TMAC_B2_LO && a <= TMAC_B2_HI) ||
            (a >= TMAC_B1_LO && a <= TMAC_B1_HI) ||
            (a >= TMAC_BLK0_LO && a < TMAC_B1_LO && !pcfg);
    endfunction
    task runMac(input logic [15:0] ta, da, input logic [31:0] ct, acc0,
                input logic [1:0] w);
        int n, cyc, mov, k, eCyc, eMov;
        logic [31:0] acc;
        logic [15:0] d, t;
        longint s;
        n = ct[23:16] + 1;
        waitN <= w;
        wr(TMAC_OFF_PREF, 32'h00001234);
        wr(TMAC_OFF_TADDR, {16'h0, ta});
        wr(TMAC_OFF_DADDR, {16'h0, da});
        wr(TMAC_OFF_ACC, acc0);
        acc = acc0;
        d = da;
        t = ta;
        eMov = 0;
        for (k = 0; k < n; k++) begin
            s = longint'($signed(acc)) + longint'($signed(shp(expP, ct[6:5])));
            if (ct[7] && s > 64'sh7fffffff) acc = TMAC_SAT_POS;
            else if (ct[7] && s < -64'sh80000000) acc = TMAC_SAT_NEG;
            else acc = s[31:0];
            if (ct[1] && inMove(d, ct[8])) eMov++;
            expP = $signed(dmv(d)) * $signed(pmv(t));
            if (k < n - 1) begin
                t++;
                if (!ct[2] && ct[4:3] == 2'd1) d++;
                if (!ct[2] && ct[4:3] == 2'd2) d--;
            end
        end
        if (ta[15:8] == TMAC_BLK0_PAGE && ct[8]) eCyc = 2 + n;
        else if (ta < TMAC_ROM_TOP) eCyc = 3 + n;
        else eCyc = 3 + n + n * w;
        wr(TMAC_OFF_CTRL, ct | 32'h1);
        cyc = 0;
        mov = 0;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
            if (busy === 1'b1) cyc++;
            if (dmWr === 1'b1) mov++;
        end while (busy === 1'b1 && k < 300);
        if (k >= 300) begin
            n_fail++;
            complete_run();
        end else begin
            check("cycles", 32'(cyc), 32'(eCyc));
            check("moves", 32'(mov), 32'(eMov));
            rdChk("ACC", TMAC_OFF_ACC, acc);
            rdChk("PROD", TMAC_OFF_PROD, expP);
            rdChk("prefetch", TMAC_OFF_PREF, 32'h00001234);
            rdChk("call stack", TMAC_OFF_CSTK, 32'h00001234);
            rdChk("DADDR", TMAC_OFF_DADDR, {16'h0, d});
            rdChk("TREG", TMAC_OFF_TREG, {16'h0, dmv(d)});
            rdChk("CTRL", TMAC_OFF_CTRL, ct & 32'h00ff01fe);
        end
    endtask
    task t_regs;
        logic [31:0] r;
        logic e;
        rdChk("CTRL", TMAC_OFF_CTRL, 32'h0);
        rdChk("STAT", TMAC_OFF_STAT, 32'h0);
        rdChk("ACC", TMAC_OFF_ACC, 32'h0);
        wr(TMAC_OFF_PROD, 32'h0000dead);
        rdChk("PROD", TMAC_OFF_PROD, 32'h0);
        apb(8'h24, 1'b0, 32'h0, r, e);
        check("unmapped err", {31'h0, e}, 32'h1);
        check("unmapped data", r, 32'h0);
        $display("test regs done");
    endtask
    task t_ram;
        // Table page ff with block zero mapped
        runMac(16'hff00, 16'h0300, 32'h00000104, 32'h0, 2'd0);
        runMac(16'hff10, 16'h0310, 32'h00030126, 32'h00000100, 2'd0);
        $display("test ram table done");
    endtask
    task t_rom_move;
        // Data below 400h, moving across blocks zero and one
        runMac(16'h0100, 16'h02fe, 32'h0003004a, 32'h0, 2'd0);
        $display("test rom table move done");
    endtask
    task t_ext;
        runMac(16'h2000, 16'h0060, 32'h00010072, 32'h0, 2'd2);
        runMac(16'h1800, 16'h0800, 32'h00000002, 32'h0, 2'd1);
        $display("test external table done");
    endtask
    task t_no_move;
        runMac(16'h0020, 16'h0004, 32'h00010002, 32'h0, 2'd0);
        runMac(16'hff20, 16'h0250, 32'h00000102, 32'h0, 2'd0);
        $display("test no move done");
    endtask
    task t_sat;
        logic [31:0] r;
        logic e;
        runMac(16'h0100, 16'h0300, 32'h00010084, 32'h7ffffff0, 2'd0);
        apb(TMAC_OFF_STAT, 1'b0, 32'h0, r, e);
        check("overflow flag", r & 32'h7, 32'h4);
        wr(TMAC_OFF_STAT, 32'h4);
        apb(TMAC_OFF_STAT, 1'b0, 32'h0, r, e);
        check("overflow clear", r & 32'h4, 32'h0);
        $display("test saturation done");
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        t_regs();
        t_ram();
        t_rom_move();
        t_ext();
        t_no_move();
        t_sat();
        complete_run();
    end
endmodule
